// File: verilog/fxo_pkg.sv
// Constants and sample carriers for the fixed-point output stage
package fxo_pkg;

    // ==========================================================
    // Format and structure defaults
    localparam int IN_W_DEF     = 24;
    localparam int IN_FRAC_DEF  = 12;
    localparam int OUT_W_DEF    = 11;
    localparam int OUT_FRAC_DEF = 9;
    localparam int LATENCY_DEF  = 1;
    localparam int BUF_DEPTH    = 2;
    localparam int WORD_W       = 32;
    localparam int ADDR_W       = 4;
    localparam int DIV_W        = 16;
    localparam int CTRL_W       = 5;
    localparam int CNT_W        = 16;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] DIV_OFS    = 4'h4;
    localparam logic [ADDR_W-1:0] STAT_OFS   = 4'h8;
    localparam logic [ADDR_W-1:0] OVFCNT_OFS = 4'hc;

    // ==========================================================
    // Control fields and reset values
    localparam int CTRL_OSIGN_BIT = 0;
    localparam int CTRL_ISIGN_BIT = 1;
    localparam int CTRL_SAT_BIT   = 2;
    localparam int CTRL_ROUND_BIT = 3;
    localparam int CTRL_FULL_BIT  = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h13;
    localparam logic [DIV_W-1:0]  DIV_RST  = 16'h0000;

    // ==========================================================
    // Status fields
    localparam int STAT_OVALID_BIT = 0;
    localparam int STAT_FULL_BIT   = 1;
    localparam int STAT_TAIL_BIT   = 2;

    // ==========================================================
    // Sample carriers
    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } in_smp_t;

    typedef struct packed {
        logic              valid;
        logic              ovf;
        logic [WORD_W-1:0] data;
    } out_smp_t;

endpackage

// File: verilog/fxo_buf.sv
// Small valid/ready buffer that absorbs a downstream stall
`timescale 1ns/1ps
module fxo_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [W-1:0]  mem_r [0:DEPTH-1];
    logic [PW-1:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic [CW-1:0] count_r;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count_r != CW'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rptr_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            if (push) wptr_r <= (wptr_r == LAST) ? '0 : wptr_r + 1'b1;
            if (pop)  rptr_r <= (rptr_r == LAST) ? '0 : rptr_r + 1'b1;
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end

    chk_buf_no_loss: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("buffer dropped a stalled word");
endmodule // fxo_buf

// File: verilog/fxo_stage.sv
// Fixed-point output stage: format reduction, latency chain, register slave
`timescale 1ns/1ps
module fxo_stage
    import fxo_pkg::*;
#(
    parameter int IN_W     = IN_W_DEF,
    parameter int IN_FRAC  = IN_FRAC_DEF,
    parameter int OUT_W    = OUT_W_DEF,
    parameter int OUT_FRAC = OUT_FRAC_DEF,
    parameter int LATENCY  = LATENCY_DEF
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire in_smp_t           in_i,
    output logic                   in_ready_o,
    output out_smp_t               out_o,
    input  wire logic              out_ready_i
);

    // ==========================================================
    // Derived format constants
    // Positive SH drops fraction bits, negative SH appends zeros
    localparam int SH  = IN_FRAC - OUT_FRAC;
    localparam int SHR = (SH > 0) ? SH : 0;
    localparam int SHL = (SH < 0) ? -SH : 0;
    localparam int BIG = (IN_W > OUT_W) ? IN_W : OUT_W;
    // Spare bits keep the sign and the rounding carry clear of overflow
    localparam int QW  = BIG + SHL + 3;
    localparam bit RND_OK = (SHR > 0);

    // Half an output LSB in input units; zero when nothing is dropped
    localparam logic signed [QW-1:0] HALF =
        RND_OK ? (QW'(1) << (RND_OK ? SHR - 1 : 0)) : QW'(0);
    localparam logic signed [QW-1:0] FMASK = (HALF <<< 1) - QW'(1);
    // Limits sized at 64 bits so a 32-bit word cannot overflow them
    localparam logic signed [QW-1:0] S_MAX =
        QW'((64'sd1 <<< (OUT_W - 1)) - 64'sd1);
    localparam logic signed [QW-1:0] S_MIN =
        QW'(-(64'sd1 <<< (OUT_W - 1)));
    localparam logic signed [QW-1:0] U_MAX =
        QW'((64'sd1 <<< OUT_W) - 64'sd1);
    localparam logic signed [QW-1:0] U_MIN = QW'(0);

    // ==========================================================
    // Register slave
    logic              ack_r;
    logic [31:0]       rdata_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [DIV_W-1:0]  div_r;
    logic [CNT_W-1:0]  ovf_cnt_r;
    logic [CNT_W-1:0]  ovf_cnt_nxt;
    logic [DIV_W-1:0]  div_nxt;
    logic [31:0]       rd_mux;
    logic [31:0]       stat_word;

    wire access   = avs_read_i | avs_write_i;
    wire wr_go    = avs_write_i & ack_r;
    wire sel_ctrl = (avs_address_i == CTRL_OFS);
    wire sel_div  = (avs_address_i == DIV_OFS);
    wire sel_stat = (avs_address_i == STAT_OFS);
    wire sel_cnt  = (avs_address_i == OVFCNT_OFS);

    // Every access waits exactly one cycle, so the read mux has a full
    // cycle before the data must stand at the completing edge.
    assign avs_waitrequest_o = access & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    assign rd_mux = sel_ctrl ? 32'(ctrl_r)    :
                    sel_div  ? 32'(div_r)     :
                    sel_stat ? stat_word      :
                    sel_cnt  ? 32'(ovf_cnt_r) :
                               32'h0000_0000;

    assign div_nxt = {
        avs_byteenable_i[1] ? avs_writedata_i[15:8] : div_r[15:8],
        avs_byteenable_i[0] ? avs_writedata_i[7:0]  : div_r[7:0]
    };

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= access & ~ack_r;
            if (access & ~ack_r) rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= CTRL_RST;
            div_r  <= DIV_RST;
        end else if (wr_go) begin
            // Control needs byte 0; a write without it changes no field
            if (sel_ctrl && avs_byteenable_i[0])
                ctrl_r <= avs_writedata_i[CTRL_W-1:0];
            if (sel_div)
                div_r <= div_nxt;
        end
    end

    // ==========================================================
    // Control decode
    wire osign    = ctrl_r[CTRL_OSIGN_BIT];
    wire isign    = ctrl_r[CTRL_ISIGN_BIT];
    wire sat_on   = ctrl_r[CTRL_SAT_BIT];
    wire full_on  = ctrl_r[CTRL_FULL_BIT];
    wire round_on = ctrl_r[CTRL_ROUND_BIT] & RND_OK;

    // ==========================================================
    // Sample-rate divider
    // DIV holds the period minus one, so zero ticks on every clock
    logic [DIV_W-1:0] div_cnt_r;

    // A lowered period takes effect at once instead of wrapping first
    wire samp_en = (div_cnt_r >= div_r);
    wire buf_ready;
    wire adv     = samp_en & buf_ready;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= samp_en ? '0 : div_cnt_r + 1'b1;
        end
    end

    assign in_ready_o = adv;

    // ==========================================================
    // Format reduction
    logic signed [QW-1:0] ext;
    logic signed [QW-1:0] rnd;
    logic signed [QW-1:0] q;
    logic signed [QW-1:0] max_q;
    logic signed [QW-1:0] min_q;
    logic [OUT_W-1:0]     word;
    logic [WORD_W-1:0]    word_ext;
    logic [WORD_W-1:0]    full_ext;
    out_smp_t             c0;

    assign ext = isign ? QW'($signed(in_i.data[IN_W-1:0]))
                       : QW'({1'b0, in_i.data[IN_W-1:0]});

    // Adding half minus one for negatives sends ties away from zero
    assign rnd = ext + (round_on ? (ext[QW-1] ? HALF - QW'(1) : HALF)
                                 : QW'(0));

    // Arithmetic shift floors, which is plain truncation of the LSBs
    assign q = (SH >= 0) ? (rnd >>> SHR) : (ext <<< SHL);

    assign max_q = osign ? S_MAX : U_MAX;
    assign min_q = osign ? S_MIN : U_MIN;

    wire ovf_hi = (q > max_q);
    wire ovf_lo = (q < min_q);

    // Wrap keeps the low OUT_W bits of q; saturate replaces them with max_q or min_q only on overflow
    assign word = (sat_on & ovf_hi) ? max_q[OUT_W-1:0] :
                  (sat_on & ovf_lo) ? min_q[OUT_W-1:0] :
                                      q[OUT_W-1:0];

    assign word_ext = osign ? WORD_W'($signed(word)) : WORD_W'(word);
    assign full_ext = isign ? WORD_W'($signed(in_i.data[IN_W-1:0]))
                            : WORD_W'(in_i.data[IN_W-1:0]);

    assign c0.valid = in_i.valid;
    assign c0.ovf   = in_i.valid & ~full_on & (ovf_hi | ovf_lo);
    assign c0.data  = full_on ? full_ext : word_ext;

    // ==========================================================
    // Latency chain after the result, stepped once per sample period
    // A zero latency leaves the loop empty and feeds the buffer directly
    out_smp_t stage [0:LATENCY];
    assign stage[0] = c0;

    genvar gi;
    generate
        for (gi = 1; gi <= LATENCY; gi++) begin : g_lat
            out_smp_t lat_r;
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    lat_r <= '0;
                end else if (adv) begin
                    lat_r <= stage[gi-1];
                end
            end
            assign stage[gi] = lat_r;
        end
    endgenerate

    out_smp_t tail;
    assign tail = stage[LATENCY];

    // ==========================================================
    // Output buffer; a full buffer freezes the chain and the input
    // Two slots let a word leave the chain while the sink still stalls
    logic [WORD_W:0] buf_dout;
    wire             buf_valid;
    wire             push = adv & tail.valid;

    fxo_buf #(
        .W     (WORD_W + 1),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_ready),
        .in_data_i   ({tail.ovf, tail.data}),
        .out_valid_o (buf_valid),
        .out_ready_i (out_ready_i),
        .out_data_o  (buf_dout)
    );

    assign out_o.valid = buf_valid;
    assign out_o.ovf   = buf_dout[WORD_W];
    assign out_o.data  = buf_dout[WORD_W-1:0];

    // ==========================================================
    // Overflow counter and status
    wire ovf_push = push & tail.ovf;
    wire cnt_clr  = wr_go & sel_cnt;

    // A count arriving with the clear survives as one
    assign ovf_cnt_nxt = cnt_clr  ? CNT_W'(ovf_push) :
                         ovf_push ? ovf_cnt_r + 1'b1 :
                                    ovf_cnt_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovf_cnt_r <= '0;
        end else begin
            ovf_cnt_r <= ovf_cnt_nxt;
        end
    end

    always_comb begin
        stat_word                  = 32'h0000_0000;
        stat_word[STAT_OVALID_BIT] = buf_valid;
        stat_word[STAT_FULL_BIT]   = ~buf_ready;
        stat_word[STAT_TAIL_BIT]   = tail.valid;
    end

    // ==========================================================
    // Checks
    // Format checks read the combinational result ahead of the chain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_frac_range: assert property (
        OUT_FRAC >= 0 && OUT_FRAC <= OUT_W)
        else $error("fraction width outside the word");

    chk_sat_clamp: assert property (
        in_i.valid && !full_on && sat_on && ovf_hi
        |-> word == max_q[OUT_W-1:0] && c0.ovf)
        else $error("saturation did not clamp high");

    chk_sat_low: assert property (
        in_i.valid && !full_on && sat_on && ovf_lo
        |-> word == min_q[OUT_W-1:0] && c0.ovf)
        else $error("saturation did not clamp low");

    chk_sat_floor: assert property (
        in_i.valid && !full_on && sat_on && !osign && q < 0
        |-> word == '0)
        else $error("unsigned saturation not zero");

    chk_wrap_bits: assert property (
        !sat_on && !full_on |-> c0.data[OUT_W-1:0] == q[OUT_W-1:0])
        else $error("wrap changed kept bits");

    chk_round_tie: assert property (
        round_on && (SH >= 0) && ((ext & FMASK) == HALF)
        |-> q == (ext >>> SHR) + (ext[QW-1] ? QW'(0) : QW'(1)))
        else $error("tie not rounded away from zero");

    chk_trunc_floor: assert property (
        !ctrl_r[CTRL_ROUND_BIT] && (SH >= 0) |-> q == (ext >>> SHR))
        else $error("truncation adjusted the value");

    chk_full_exact: assert property (
        full_on && in_i.valid
        |-> c0.data[IN_W-1:0] == in_i.data[IN_W-1:0] && !c0.ovf)
        else $error("full precision altered the sample");

    chk_ovf_flag: assert property (
        ovf_push && !cnt_clr
        |=> ovf_cnt_r == $past(ovf_cnt_r) + CNT_W'(1))
        else $error("overflow sample not counted");

    chk_cnt_hold: assert property (
        !ovf_push && !cnt_clr |=> $stable(ovf_cnt_r))
        else $error("overflow count moved without a sample");

    chk_cnt_clear: assert property (
        cnt_clr && !ovf_push |=> ovf_cnt_r == '0)
        else $error("overflow count not cleared");

    chk_bus_answer: assert property (
        access && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus access not answered");

    // A period written in the tick cycle may legally shorten the gap
    chk_sample_gap: assert property (
        adv && div_r != '0 && !(wr_go && sel_div) |=> !adv)
        else $error("two sample ticks inside one period");

    chk_out_hold: assert property (
        out_o.valid && !out_ready_i |=> out_o.valid && $stable(out_o))
        else $error("stalled output sample changed");

    generate
        if (LATENCY > 0) begin : g_chk
            chk_chain_step: assert property (
                adv |=> stage[1] == $past(c0))
                else $error("chain did not take the result");

            chk_chain_hold: assert property (
                !adv |=> $stable(tail))
                else $error("chain moved without a sample period");
        end
    endgenerate

    cov_sat_hit: cover property (
        in_i.valid && adv && sat_on && (ovf_hi || ovf_lo));
    cov_round_tie: cover property (
        in_i.valid && adv && round_on && ((ext & FMASK) == HALF));
    cov_stall: cover property (
        buf_valid && !out_ready_i ##1 !buf_ready);
    cov_wrap_ovf: cover property (
        in_i.valid && adv && !sat_on && !full_on && (ovf_hi || ovf_lo));
    cov_cnt_clear: cover property (
        cnt_clr && ovf_cnt_r != '0);

endmodule // fxo_stage

// File: testbench/fxo_sink.sv
// Downstream sink model for the fixed-point output stage
`timescale 1ns/1ps
module fxo_sink
    import fxo_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_b_i,
    input  wire logic     stall_i,
    input  wire out_smp_t smp_i,
    output logic          ready_o,
    output logic [3:0]    rx_cnt_o,
    output out_smp_t      rx_o [16]
);
    // ==========================================================
    // Acceptance
    // Ready drops for as long as the bench asks for a stall
    assign ready_o = ~stall_i;

    // Only a word with its valid flag set is stored and counted
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_cnt_o <= 4'h0;
        end else if (smp_i.valid && ready_o) begin
            rx_o[rx_cnt_o] <= smp_i;
            rx_cnt_o       <= rx_cnt_o + 4'h1;
        end
    end
endmodule // fxo_sink

// File: testbench/fixed_point_output_stage_bench.sv
// Self-checking bench for the fixed-point output stage
`timescale 1ns/1ps
module fixed_point_output_stage_bench import fxo_pkg::*;;
    // ==========================================================
    // Signals
    localparam int SH = IN_FRAC_DEF - OUT_FRAC_DEF;
    logic              clk_i;
    logic              rst_b_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic              avs_read_i;
    logic              avs_write_i;
    logic [31:0]       avs_writedata_i;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    in_smp_t           in_i;
    logic              in_ready_o;
    out_smp_t          out_o;
    logic              out_ready_i;
    logic              stall;
    logic [3:0]        rx_cnt;
    out_smp_t          rx [16];
    logic [31:0]       rdv;
    logic [32:0]       e;
    int                fails;
    int                cmp_count;
    int                idx;
    int                novf;
    logic [4:0]  ct [11] = '{5'h0f, 5'h0f, 5'h07, 5'h07, 5'h07,
                             5'h03, 5'h13, 5'h06, 5'h04, 5'h0b, 5'h10};
    logic [31:0] dv [11] = '{32'h14, 32'hffffec, 32'h17, 32'h7fffff,
                             32'h800000, 32'h2008, 32'hffffec, 32'hffffec,
                             32'h3ff8, 32'h1ffc, 32'hffffec};

    fxo_stage dut_u (
        .clk_i             (clk_i),
        .rst_b_i           (rst_b_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (4'hf),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .in_i              (in_i),
        .in_ready_o        (in_ready_o),
        .out_o             (out_o),
        .out_ready_i       (out_ready_i)
    );

    fxo_sink sink_u (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .stall_i  (stall),
        .smp_i    (out_o),
        .ready_o  (out_ready_i),
        .rx_cnt_o (rx_cnt),
        .rx_o     (rx)
    );

    // ==========================================================
    // Reference model: {ovf, 32-bit output} for a raw input word
    function automatic logic [32:0] ref_f(input logic [31:0] raw,
                                          input logic [4:0]  c);
        longint v, q, lo, hi, m, h;
        logic   ov;
        v  = c[1] ? longint'(signed'(raw[IN_W_DEF-1:0]))
                  : longint'(raw[IN_W_DEF-1:0]);
        h  = longint'(1) << (SH - 1);
        m  = (longint'(1) << OUT_W_DEF) - 1;
        lo = c[0] ? -(m + 1) / 2 : 0;
        hi = c[0] ? m / 2 : m;
        // Ties go away from zero, so the magnitude is rounded
        q  = !c[3] ? v >>> SH : v < 0 ? -((h - v) >>> SH) : (v + h) >>> SH;
        ov = q < lo || q > hi;
        if (c[2]) q = q < lo ? lo : (q > hi ? hi : q);
        q = q & m;
        if (c[0] && q[OUT_W_DEF-1]) q = q | ~m;
        return c[4] ? {1'b0, v[31:0]} : {ov, q[31:0]};
    endfunction

    // ==========================================================
    // Compare and closing tasks
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_smp(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 200) begin
            fails++;
            report_and_stop();
        end
    endtask

    // ==========================================================
    // Bus and stream drivers
    // Ends one edge after release, so a following access never
    // assigns the strobe twice in one time step
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 200);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        tmo(n);
        @(posedge clk_i);
    endtask

    // Keep holds valid so the next word follows back to back
    task automatic put(input logic [31:0] d, input logic keep);
        int n;
        in_i <= '{valid: 1'b1, data: d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (in_ready_o !== 1'b1 && n < 200);
        if (!keep) in_i.valid <= 1'b0;
        tmo(n);
    endtask

    task automatic wait_rx(input int t);
        int n;
        n = 0;
        while (rx_cnt !== t[3:0] && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        tmo(n);
    endtask

    task automatic lat(input int exp);
        int n;
        put(32'h100, 1'b0);
        n = 0;
        while (out_o.valid !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        cmp_reg(32'(n), 32'(exp));
        wait_rx(idx + 1);
        idx++;
    endtask

    // ==========================================================
    // Clock and main sequence
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_b_i = 1'b0;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        in_i = '0;
        stall = 1'b0;
        fails = 0;
        cmp_count = 0;
        idx = 0;
        novf = 0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        cmp_reg({31'h0, out_o.valid}, 32'h0);
        av(1'b0, CTRL_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'h13);
        av(1'b0, DIV_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'h0);
        av(1'b1, STAT_OFS, 32'hffffffff, rdv);
        av(1'b0, STAT_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'h0);
        av(1'b0, 4'h2, 32'h0, rdv);
        cmp_reg(rdv, 32'h0);
        lat(2);
        av(1'b1, DIV_OFS, 32'h3, rdv);
        lat(5);
        av(1'b1, DIV_OFS, 32'h0, rdv);
        for (int i = 0; i < 11; i++) begin
            av(1'b1, CTRL_OFS, {27'h0, ct[i]}, rdv);
            put(dv[i], 1'b0);
            wait_rx(idx + 1);
            e = ref_f(dv[i], ct[i]);
            cmp_smp({rx[idx[3:0]].ovf, rx[idx[3:0]].data}, e);
            novf += int'(e[32]);
            idx++;
        end
        av(1'b0, OVFCNT_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'(novf));
        av(1'b1, OVFCNT_OFS, 32'h0, rdv);
        av(1'b0, OVFCNT_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'h0);
        // Stalled sink: chain plus two buffer slots hold three words
        av(1'b1, CTRL_OFS, 32'h13, rdv);
        stall <= 1'b1;
        put(32'h11, 1'b1);
        put(32'hfffff2, 1'b1);
        put(32'h33, 1'b0);
        repeat (5) @(posedge clk_i);
        cmp_reg({31'h0, in_ready_o}, 32'h0);
        av(1'b0, STAT_OFS, 32'h0, rdv);
        cmp_reg(rdv, 32'h7);
        stall <= 1'b0;
        wait_rx(idx + 3);
        cmp_smp({rx[idx[3:0]].ovf, rx[idx[3:0]].data}, ref_f(32'h11, 5'h13));
        idx++;
        cmp_smp({rx[idx[3:0]].ovf, rx[idx[3:0]].data}, ref_f(32'hfffff2, 5'h13));
        idx++;
        cmp_smp({rx[idx[3:0]].ovf, rx[idx[3:0]].data}, ref_f(32'h33, 5'h13));
        report_and_stop();
    end
endmodule // fixed_point_output_stage_bench
